/* File: hdl/gpint_port.sv */
// 64-pin general-purpose I/O block with seven interrupt pins
//
// Function
// - Data low bits 31:0 map to pins 0-31 and data high bits to pins 32-63.
// - An input pin's level is copied into its data bit so reads show the pin.
// - An output pin is driven from its data bit.
// - A direction bit of zero makes the pin an input, one an output.
// - Setup bits 6:0 turn pins 48-54 into interrupt inputs.
// - Setup bits 22:16 pick edge (0) or level (1) detection.
// - Setup bits 14:8 pick low/falling (0) or high/rising (1) sense.
// - An event on an enabled interrupt pin sets a sticky status bit in 22:16.
// - Writing one to bit 22:16 of the clear register clears that status unless an event sets it in the same cycle; zeros do nothing.
// - Status read and clear write share one address.
// - All registers reset to zero, so all pins start as inputs and no interrupts.
// - Register offsets are fixed; only the base may move.
`timescale 1ns/1ps
`include "gpint_map.svh"
module gpint_port
   import gpint_pkg::*;
#(
   parameter int PIN_COUNT = `GPINT_PIN_COUNT
)
(
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // Register access, offset from block base
   input  wire logic [`GPINT_ADDR_WIDTH-1:0]   regAddr,
   input  wire logic                           regWrite,
   input  wire logic                           regRead,
   input  wire logic [31:0]                    regWdata,
   output logic      [31:0]                    regRdata,
   // Pins
   input  wire logic [PIN_COUNT-1:0]           pinIn,
   output logic      [PIN_COUNT-1:0]           pinOut,
   output logic      [PIN_COUNT-1:0]           pinOe,
   // Interrupt request
   output logic                                irqReq
);
   typedef struct packed {
      gpint_pins_type data;
      gpint_pins_type dir;
      logic [31:0]    setup;
      gpint_pins_type sync1;
      gpint_pins_type sync2;
      logic [31:0]    rdata;
   } gpint_state_type;

   gpint_state_type s_q;
   gpint_state_type s_d;
   gpint_irq_type   irqStatus;
   gpint_irq_type   clearReq;
   gpint_irq_type   intEnable;
   logic [31:0]     statusWord;
   logic            addrMapped;

   assign intEnable = s_q.setup[`GPINT_ENABLE_LSB +: `GPINT_INT_COUNT];
   assign clearReq  = (regWrite && regAddr == `GPINT_OFS_INT_STATUS) ?
                      regWdata[`GPINT_STATUS_LSB +: `GPINT_INT_COUNT] : '0;

   // Offsets that decode to a register; every other offset is refused
   assign addrMapped = regAddr == `GPINT_OFS_DATA_LOW || regAddr == `GPINT_OFS_DATA_HIGH ||
                       regAddr == `GPINT_OFS_DIR_LOW || regAddr == `GPINT_OFS_DIR_HIGH ||
                       regAddr == `GPINT_OFS_INT_SETUP || regAddr == `GPINT_OFS_INT_STATUS;

   genvar g;
   generate
      for (g = 0; g < `GPINT_INT_COUNT; g++)
      begin : gIrq
         gpint_irq_detect u_det (
            .clk        (clk),
            .rst        (rst),
            .pinIn      (pinIn[`GPINT_INT_FIRST_PIN + g]),
            .enable     (intEnable[g]),
            .activeHigh (s_q.setup[`GPINT_ACTIVE_LSB + g]),
            .levelMode  (s_q.setup[`GPINT_TRIGGER_LSB + g]),
            .clearReq   (clearReq[g]),
            .status     (irqStatus[g])
         );
      end
   endgenerate

   always_comb
   begin
      statusWord = '0;
      statusWord[`GPINT_STATUS_LSB +: `GPINT_INT_COUNT] = irqStatus;
   end

   always_comb
   begin
      s_d       = s_q;
      s_d.sync1 = pinIn;
      s_d.sync2 = s_q.sync1;
      // Input pins follow the pin; output pins keep the written value
      s_d.data  = (s_q.data & s_q.dir) | (s_q.sync2 & ~s_q.dir);
      if (regWrite)
      begin
         case (regAddr)
            `GPINT_OFS_DATA_LOW:  s_d.data[31:0]  = (regWdata & s_q.dir[31:0]) | (s_q.sync2[31:0] & ~s_q.dir[31:0]);
            `GPINT_OFS_DATA_HIGH: s_d.data[63:32] = (regWdata & s_q.dir[63:32]) | (s_q.sync2[63:32] & ~s_q.dir[63:32]);
            `GPINT_OFS_DIR_LOW:   s_d.dir[31:0]   = regWdata;
            `GPINT_OFS_DIR_HIGH:  s_d.dir[63:32]  = regWdata;
            `GPINT_OFS_INT_SETUP: s_d.setup       = regWdata & 32'h007F7F7F;
            default:              s_d.setup       = s_q.setup;
         endcase
      end
      // Read data lands one cycle after regRead; unmapped offsets read zero
      s_d.rdata = `GPINT_RESET_VALUE;
      if (regRead)
      begin
         case (regAddr)
            `GPINT_OFS_DATA_LOW:   s_d.rdata = s_q.data[31:0];
            `GPINT_OFS_DATA_HIGH:  s_d.rdata = s_q.data[63:32];
            `GPINT_OFS_DIR_LOW:    s_d.rdata = s_q.dir[31:0];
            `GPINT_OFS_DIR_HIGH:   s_d.rdata = s_q.dir[63:32];
            `GPINT_OFS_INT_SETUP:  s_d.rdata = s_q.setup;
            `GPINT_OFS_INT_STATUS: s_d.rdata = statusWord;
            default:               s_d.rdata = `GPINT_RESET_VALUE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign pinOut   = s_q.data;
   assign pinOe    = s_q.dir;
   assign regRdata = s_q.rdata;
   assign irqReq   = |irqStatus;

   a_out_follows: assert property (@(posedge clk) disable iff (rst)
      s_q.dir[31] && !(regWrite && regAddr == `GPINT_OFS_DATA_LOW) |=> pinOut[31] == $past(pinOut[31]))
      else $error("output pin drifted");
   a_input_copy: assert property (@(posedge clk) disable iff (rst)
      !s_q.dir[0] && !$past(rst) |=> s_q.data[0] == $past(s_q.sync2[0])) else $error("input not copied");
   a_dir_write: assert property (@(posedge clk) disable iff (rst)
      regWrite && regAddr == `GPINT_OFS_DIR_LOW |=> s_q.dir[31:0] == $past(regWdata)) else $error("dir write lost");
   a_irq_any: assert property (@(posedge clk) disable iff (rst)
      regRead && regAddr == `GPINT_OFS_INT_STATUS |=> $past(irqReq) == (regRdata[22:16] != 7'h00))
      else $error("irq output wrong");
   a_status_read: assert property (@(posedge clk) disable iff (rst)
      regRead && regAddr == `GPINT_OFS_INT_STATUS |=> regRdata[15:0] == 16'h0000) else $error("status low bits");
   a_reset_zero: assert property (@(posedge clk)
      rst |=> s_q.dir == '0 && s_q.setup == '0) else $error("reset not zero");
   a_setup_write: assert property (@(posedge clk) disable iff (rst)
      regWrite && regAddr == `GPINT_OFS_INT_SETUP |=> s_q.setup[6:0] == $past(regWdata[6:0]))
      else $error("setup lost");
   a_data_write: assert property (@(posedge clk) disable iff (rst)
      regWrite && regAddr == `GPINT_OFS_DATA_HIGH && s_q.dir[32] |=> s_q.data[32] == $past(regWdata[0]))
      else $error("data high");

   // Register-side steps shared by the checks below
   sequence s_wr_data_low;
      regWrite && regAddr == `GPINT_OFS_DATA_LOW;
   endsequence

   sequence s_wr_dir_high;
      regWrite && regAddr == `GPINT_OFS_DIR_HIGH;
   endsequence

   sequence s_wr_setup;
      regWrite && regAddr == `GPINT_OFS_INT_SETUP;
   endsequence

   sequence s_wr_status;
      regWrite && regAddr == `GPINT_OFS_INT_STATUS;
   endsequence

   sequence s_wr_unmapped;
      regWrite && !addrMapped;
   endsequence

   sequence s_rd_status;
      regRead && regAddr == `GPINT_OFS_INT_STATUS;
   endsequence

   sequence s_rd_unmapped;
      regRead && !addrMapped;
   endsequence

   property p_out_write;
      @(posedge clk) disable iff (rst)
      s_wr_data_low ##0 s_q.dir[31] |=> pinOut[31] == $past(regWdata[31]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("output pin missed write");

   property p_input_ignore;
      @(posedge clk) disable iff (rst)
      s_wr_data_low ##0 !s_q.dir[1] |=> s_q.data[1] == $past(s_q.sync2[1]);
   endproperty
   a_input_ignore: assert property (p_input_ignore) else $error("input bit took write");

   property p_dir_high;
      @(posedge clk) disable iff (rst)
      s_wr_dir_high |=> pinOe[63:32] == $past(regWdata);
   endproperty
   a_dir_high: assert property (p_dir_high) else $error("high direction lost");

   property p_setup_fields;
      @(posedge clk) disable iff (rst)
      s_wr_setup |=> s_q.setup[22:8] == {$past(regWdata[22:16]), 1'h0, $past(regWdata[14:8])}
         && s_q.setup[31:23] == 9'h000 && s_q.setup[7] == 1'h0;
   endproperty
   a_setup_fields: assert property (p_setup_fields) else $error("setup fields wrong");

   property p_zero_write;
      @(posedge clk) disable iff (rst)
      s_wr_status ##0 regWdata[22:16] == 7'h00 |=> (irqStatus & $past(irqStatus)) == $past(irqStatus);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write cleared status");

   property p_unmapped_wr;
      @(posedge clk) disable iff (rst)
      s_wr_unmapped |=> s_q.dir == $past(s_q.dir) && s_q.setup == $past(s_q.setup);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr) else $error("unmapped write landed");

   property p_rd_unmapped;
      @(posedge clk) disable iff (rst)
      s_rd_unmapped |=> regRdata == 32'h00000000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

   property p_status_word;
      @(posedge clk) disable iff (rst)
      s_rd_status |=> regRdata[22:16] == $past(irqStatus) && regRdata[31:23] == 9'h000;
   endproperty
   a_status_word: assert property (p_status_word) else $error("status read wrong");

   property p_rdata_idle;
      @(posedge clk) disable iff (rst)
      !regRead |=> regRdata == 32'h00000000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule

/* File: inc/gpint_map.svh */
// Register offsets, field positions and reset values of the pin I/O block
`ifndef GPINT_MAP_SVH
`define GPINT_MAP_SVH

`define GPINT_OFS_DATA_LOW     24'h010000
`define GPINT_OFS_DATA_HIGH    24'h010004
`define GPINT_OFS_DIR_LOW      24'h010008
`define GPINT_OFS_DIR_HIGH     24'h01000C
`define GPINT_OFS_INT_SETUP    24'h010010
`define GPINT_OFS_INT_STATUS   24'h010014
`define GPINT_ADDR_WIDTH       24
`define GPINT_RESET_VALUE      32'h00000000
`define GPINT_PIN_COUNT        64
`define GPINT_INT_COUNT        7
`define GPINT_INT_FIRST_PIN    48
`define GPINT_ENABLE_LSB       0
`define GPINT_ACTIVE_LSB       8
`define GPINT_TRIGGER_LSB      16
`define GPINT_STATUS_LSB       16

`endif

/* File: inc/gpint_pkg.sv */
// Types shared by the pin I/O block
package gpint_pkg;
   typedef logic [6:0]  gpint_irq_type;
   typedef logic [63:0] gpint_pins_type;
endpackage

/* File: hdl/gpint_irq_detect.sv */
// Per-pin interrupt detector: synchroniser, edge or level detection, sticky status
`timescale 1ns/1ps
`include "gpint_map.svh"
module gpint_irq_detect
   import gpint_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Pin and configuration
   input  wire logic pinIn,
   input  wire logic enable,
   input  wire logic activeHigh,
   input  wire logic levelMode,
   input  wire logic clearReq,
   // Status
   output logic      status
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic stat;
   } gpint_det_type;

   gpint_det_type s_q;
   gpint_det_type s_d;
   logic          asserted;
   logic          prevAsserted;
   logic          event_;

   always_comb
   begin
      s_d          = s_q;
      s_d.sync1    = pinIn;
      s_d.sync2    = s_q.sync1;
      s_d.prev     = s_q.sync2;
      asserted     = activeHigh ? s_q.sync2 : ~s_q.sync2;
      prevAsserted = activeHigh ? s_q.prev : ~s_q.prev;
      event_       = enable & (levelMode ? asserted : (asserted & ~prevAsserted));
      // Set wins over a simultaneous clear so no event is lost
      if (event_)
         s_d.stat = 1'b1;
      else if (clearReq)
         s_d.stat = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign status = s_q.stat;

   a_sticky_hold: assert property (@(posedge clk) disable iff (rst)
      s_q.stat && !clearReq |=> s_q.stat) else $error("status dropped without clear");
   a_clear_works: assert property (@(posedge clk) disable iff (rst)
      clearReq && !event_ |=> !s_q.stat) else $error("clear did not take");
   a_set_wins: assert property (@(posedge clk) disable iff (rst)
      event_ && clearReq |=> s_q.stat) else $error("clear beat event");
endmodule

/* File: verification/gpint_pin_model.sv */
// Far-side devices wired to the general-purpose pins
`timescale 1ns/1ps
module gpint_pin_model
(
   // Pin wires
   input  wire logic [63:0] pinOut,
   input  wire logic [63:0] pinOe,
   output logic      [63:0] pinIn,
   // Level the external devices put on pins the block leaves undriven
   input  wire logic [63:0] extLevel
);
   // A driven pin shows the block's own value, so input sampling sees the wire
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the pin I/O block
`timescale 1ns/1ps
`include "gpint_map.svh"
module tb_top
   import gpint_pkg::*;
;
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic [23:0]    regAddr = 24'h000000;
   logic           regWrite = 1'b0;
   logic           regRead = 1'b0;
   logic [31:0]    regWdata = 32'h00000000;
   logic [31:0]    regRdata;
   gpint_pins_type pinIn, pinOut, pinOe;
   gpint_pins_type extLevel = 64'h0;
   logic           irqReq;
   int             n_fail = 0;
   int             checks_done = 0;
   always #2.5 clk = ~clk;
   gpint_port dut_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .irqReq(irqReq));
   gpint_pin_model pins_u (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn), .extLevel(extLevel));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      @(posedge clk) #1;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      idle(1);
      regWrite = 1'b0;
   endtask
   // Read data stands one cycle only, so it is judged right after the answer edge
   task automatic rd(input logic [23:0] a, input logic [31:0] exp);
      @(posedge clk) #1;
      regAddr = a;
      regRead = 1'b1;
      idle(1);
      regRead = 1'b0;
      chk({32'h0, regRdata}, {32'h0, exp});
   endtask
   task automatic t_reset;
      for (int i = 0; i < 6; i++)
         rd(24'h010000 + 24'(i * 4), 32'h00000000);
      chk(pinOe, 64'h0);
      chk({63'h0, irqReq}, 64'h0);
   endtask
   task automatic t_output;
      wr(`GPINT_OFS_DIR_LOW, 32'hFFFF0000);
      wr(`GPINT_OFS_DIR_HIGH, 32'h0000FFFF);
      wr(`GPINT_OFS_DATA_LOW, 32'h12345678);
      wr(`GPINT_OFS_DATA_HIGH, 32'h9ABCDEF0);
      chk(pinOe, 64'h0000FFFF_FFFF0000);
      chk(pinOut & pinOe, 64'h0000DEF0_12340000);
      extLevel = 64'hFFFF0000_0000FFFF;
      idle(5);
      rd(`GPINT_OFS_DATA_LOW, 32'h1234FFFF);
      rd(`GPINT_OFS_DATA_HIGH, 32'hFFFFDEF0);
      wr(`GPINT_OFS_DIR_LOW, 32'h00000000);
      wr(`GPINT_OFS_DIR_HIGH, 32'h00000000);
      extLevel = 64'h0;
      idle(5);
   endtask
   task automatic t_edge;
      wr(`GPINT_OFS_INT_SETUP, 32'h00000101);
      rd(`GPINT_OFS_INT_SETUP, 32'h00000101);
      extLevel[48] = 1'b1;
      idle(6);
      chk({63'h0, irqReq}, 64'h1);
      rd(`GPINT_OFS_INT_STATUS, 32'h00010000);
      wr(`GPINT_OFS_INT_STATUS, 32'h00000000);
      rd(`GPINT_OFS_INT_STATUS, 32'h00010000);
      wr(`GPINT_OFS_INT_STATUS, 32'h00010000);
      idle(4);
      // Pin still high: an edge-mode pin must not set again after the clear
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
      chk({63'h0, irqReq}, 64'h0);
      extLevel[48] = 1'b0;
      idle(6);
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
   endtask
   task automatic t_level;
      // Disarm pin 48 first, or raising it below would log a rising edge
      wr(`GPINT_OFS_INT_SETUP, 32'h00000000);
      extLevel[54:48] = 7'h7F;
      idle(5);
      wr(`GPINT_OFS_INT_SETUP, 32'h00400040);
      idle(6);
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
      extLevel[54] = 1'b0;
      extLevel[49] = 1'b0;
      idle(6);
      rd(`GPINT_OFS_INT_STATUS, 32'h00400000);
      wr(`GPINT_OFS_INT_STATUS, 32'h00400000);
      rd(`GPINT_OFS_INT_STATUS, 32'h00400000);
      extLevel[54] = 1'b1;
      idle(6);
      wr(`GPINT_OFS_INT_STATUS, 32'h00400000);
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
      // Unmapped offset just past the status register: write ignored, read zero
      wr(24'h010018, 32'hFFFFFFFF);
      rd(24'h010018, 32'h00000000);
      rd(`GPINT_OFS_INT_SETUP, 32'h00400040);
      wr(`GPINT_OFS_INT_SETUP, 32'hFFFFFFFF);
      rd(`GPINT_OFS_INT_SETUP, 32'h007F7F7F);
      wr(`GPINT_OFS_INT_SETUP, 32'h00000000);
      wr(`GPINT_OFS_INT_STATUS, 32'h007F0000);
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
   endtask
   task automatic t_fall;
      wr(`GPINT_OFS_INT_SETUP, 32'h00000002);
      extLevel[49] = 1'b1;
      idle(6);
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
      extLevel[49] = 1'b0;
      idle(6);
      rd(`GPINT_OFS_INT_STATUS, 32'h00020000);
      chk({63'h0, irqReq}, 64'h1);
      wr(`GPINT_OFS_INT_STATUS, 32'h00020000);
      rd(`GPINT_OFS_INT_STATUS, 32'h00000000);
   endtask
   task automatic t_midreset;
      wr(`GPINT_OFS_DIR_HIGH, 32'hFFFFFFFF);
      wr(`GPINT_OFS_DATA_HIGH, 32'hA5A5A5A5);
      chk(pinOut & pinOe, 64'hA5A5A5A5_00000000);
      @(posedge clk) #1;
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      chk(pinOe, 64'h0);
      chk(pinOut, 64'h0);
      chk({63'h0, irqReq}, 64'h0);
      rd(`GPINT_OFS_DIR_HIGH, 32'h00000000);
      rd(`GPINT_OFS_INT_SETUP, 32'h00000000);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      idle(16);
      rst = 1'b0;
      t_reset;
      t_output;
      t_edge;
      t_level;
      t_fall;
      t_midreset;
      finish_test;
   end
   initial
   begin
      #20000;
      n_fail++;
      finish_test;
   end
endmodule
